// ### hdl/slave_bus_defs.svh
// Purpose: Constants for the slave bus decode and inhibit front end
// Assumes: 125 MHz local clock, 8 ns period
// Notes:   Times in ns, cycle counts derived from them except PLAIN_ACK_DELAY_CYC
`ifndef SLAVE_BUS_DEFS_SVH
`define SLAVE_BUS_DEFS_SVH

// ==========================================================================
// Timing
`define CLK_PERIOD_NS          8
`define INHIBIT_ASSERT_LIMIT_NS 100
`define ADDR_TO_CMD_SETUP_NS   50
`define ACK_RELEASE_LIMIT_NS   100
`define OVERLAY_ACK_DELAY_NS   1500
// Longest times round down, least times round up
`define INHIBIT_ASSERT_CYC     (`INHIBIT_ASSERT_LIMIT_NS / `CLK_PERIOD_NS)
`define ACK_RELEASE_CYC        (`ACK_RELEASE_LIMIT_NS / `CLK_PERIOD_NS)
`define OVERLAY_ACK_DELAY_CYC  ((`OVERLAY_ACK_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Plain acknowledge delay when not overlaying
`define PLAIN_ACK_DELAY_CYC    2

// ==========================================================================
// Address layout
`define ADDR_W                 8
`define DEV_LSB                0
`define MID_LSB                3
`define TOP_LSB                6
`define DATA_W                 8

`endif

// ### hdl/slave_bus_pkg.sv
// Purpose: Types for the slave bus decode and inhibit front end
// Assumes: slave_bus_defs.svh included first
// Notes:   Command group travels as one packed struct
`include "slave_bus_defs.svh"
package slave_bus_pkg;
  // Active-low bus commands
  typedef struct packed {
    logic mem_read_cmd_n;
    logic mem_write_cmd_n;
    logic io_read_cmd_n;
    logic io_write_cmd_n;
  } bus_cmd_s;

  // Active-high local strobes
  typedef struct packed {
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
  } local_strobe_s;

  // Acknowledge sequencer
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01,
    ACK_DONE = 2'b11
  } ack_state_e;
endpackage

// ### hdl/slave_bus_decode_inhibit.sv
// Purpose: Slave front end: two-stage decode, strobes, data drive, inhibit
// Assumes: Address stable before and after command; commands async
// Notes:   Decode path is combinational then registered once
`timescale 1ns/1ps
`include "slave_bus_defs.svh"

module slave_bus_decode_inhibit #(
  parameter int unsigned ACK_DELAY_CYC = `OVERLAY_ACK_DELAY_CYC,
  parameter int unsigned ADDR_W        = `ADDR_W,
  parameter int unsigned DATA_W        = `DATA_W
) (
  // Clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        rstn_in,
  // Bus address and commands
  input  wire logic [ADDR_W-1:0]           bus_addr_in,
  input  wire slave_bus_pkg::bus_cmd_s     bus_cmd_in,
  input  wire logic [DATA_W-1:0]           bus_data_in,
  // Inhibit from other slaves
  input  wire logic                        overlay_inhibit_n_in,
  // Jumpers and mode
  input  wire logic [2:0]                  base_sel_in,
  input  wire logic [1:0]                  base_top_in,
  input  wire logic                        overlay_en_in,
  input  wire logic                        boot_overlay_in,
  input  wire logic                        boot_done_in,
  // User logic
  input  wire logic [DATA_W-1:0]           user_rd_data_in,
  output logic [7:0]                       dev_sel_out,
  output slave_bus_pkg::local_strobe_s     strobe_out,
  output logic [DATA_W-1:0]                user_wr_data_out,
  // Bus outputs
  output logic [DATA_W-1:0]                bus_data_out,
  output logic                             bus_data_oe_out,
  output logic                             transfer_ack_n_out,
  output logic                             transfer_ack_oe_out,
  output logic                             overlay_inhibit_n_out
);
  import slave_bus_pkg::*;

  // ========================================================================
  // Decode functions
  // One-hot of three bits, gated by an enable
  function automatic logic [7:0] one_of_eight(input logic [2:0] sel, input logic en);
    logic [7:0] res;
    res = 8'h00;
    if (en) begin
      res[sel] = 1'b1;
    end
    return res;
  endfunction

  // ========================================================================
  // Synchronisers
  logic [3:0] cmd_meta_r;   // First stage, read only by second
  logic [3:0] cmd_sync_r;   // Active-high commands, synchronised
  logic       inh_meta_r;   // First stage for inhibit
  logic       inh_sync_r;   // Inhibit seen, active high

  // Two-flop capture of commands and inhibit
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_meta_r <= 4'h0;
      cmd_sync_r <= 4'h0;
      inh_meta_r <= 1'b0;
      inh_sync_r <= 1'b0;
    end else begin
      cmd_meta_r <= ~bus_cmd_in;
      cmd_sync_r <= cmd_meta_r;
      inh_meta_r <= ~overlay_inhibit_n_in;
      inh_sync_r <= inh_meta_r;
    end
  end

  // ========================================================================
  // Two-stage address decode
  logic [7:0] mid_dec;     // First stage decoder outputs
  logic       base_match;  // Selected first stage output
  logic [7:0] dev_dec;     // Second stage selects
  logic       boot_ok_r;   // Boot condition still active
  logic       overlay_hit; // This slave overrides the range

  // Boot condition from reset until boot finished
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      boot_ok_r <= 1'b1;
    end else if (boot_done_in) begin
      boot_ok_r <= 1'b0;
    end
  end

  // Shallow decode: top bits enable, mid bits one-of-eight
  always_comb begin
    mid_dec = one_of_eight(bus_addr_in[`TOP_LSB-1:`MID_LSB],
                           bus_addr_in[ADDR_W-1:`TOP_LSB] == base_top_in);
    base_match = mid_dec[base_sel_in];
    dev_dec = one_of_eight(bus_addr_in[`MID_LSB-1:`DEV_LSB], base_match);
    // Boot overlay only counts in boot condition
    overlay_hit = overlay_en_in && base_match &&
                  (!boot_overlay_in || boot_ok_r);
  end

  // ========================================================================
  // Selects and strobes
  logic       any_cmd;     // Some command present
  logic       rd_cmd;      // Read command present
  logic       sel_live;    // Match and not inhibited
  logic       match_r;     // Registered match for ack path

  always_comb begin
    any_cmd  = |cmd_sync_r;
    rd_cmd   = cmd_sync_r[3] | cmd_sync_r[1];
    sel_live = base_match && !inh_sync_r && (!boot_overlay_in || overlay_hit);
  end

  // Registered selects, strobes and data paths
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dev_sel_out      <= 8'h00;
      strobe_out       <= '0;
      match_r          <= 1'b0;
      bus_data_out     <= '0;
      bus_data_oe_out  <= 1'b0;
      user_wr_data_out <= '0;
    end else begin
      match_r <= sel_live;
      // Inhibit drops local select at once
      dev_sel_out <= sel_live ? dev_dec : 8'h00;
      strobe_out  <= sel_live ? local_strobe_s'(cmd_sync_r) : '0;
      // Read drive only with read command and match
      bus_data_oe_out <= sel_live && rd_cmd;
      bus_data_out    <= (sel_live && rd_cmd) ? user_rd_data_in : '0;
      // Receiver always open for hold time
      user_wr_data_out <= bus_data_in;
    end
  end

  // ========================================================================
  // Inhibit output
  // Registered once: 8 ns, well inside the limit
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      overlay_inhibit_n_out <= 1'b1;
    end else begin
      overlay_inhibit_n_out <= !overlay_hit;
    end
  end

  // ========================================================================
  // Acknowledge sequencer
  localparam int unsigned CNT_W = $clog2(ACK_DELAY_CYC + 2);
  ack_state_e             ack_state_r;  // Sequencer state
  logic [CNT_W-1:0]       ack_cnt_r;    // Delay counter
  logic [CNT_W-1:0]       ack_limit;    // Delay for this cycle
  logic                   ovl_cycle_r;  // Cycle is an overlay cycle

  always_comb begin
    ack_limit = ovl_cycle_r ? CNT_W'(ACK_DELAY_CYC)
                            : CNT_W'(`PLAIN_ACK_DELAY_CYC);
  end

  // Wait delay, hold ack until command goes away
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_state_r         <= ACK_IDLE;
      ack_cnt_r           <= '0;
      ovl_cycle_r         <= 1'b0;
      transfer_ack_n_out  <= 1'b1;
      transfer_ack_oe_out <= 1'b0;
    end else begin
      case (ack_state_r)
        ACK_IDLE: begin
          ack_cnt_r           <= '0;
          transfer_ack_n_out  <= 1'b1;
          transfer_ack_oe_out <= 1'b0;
          // Start on addressed command, never while inhibited
          if (any_cmd && match_r && !inh_sync_r) begin
            ack_state_r         <= ACK_WAIT;
            ovl_cycle_r         <= overlay_hit;
            transfer_ack_oe_out <= 1'b1;
          end
        end
        ACK_WAIT: begin
          // Abort if inhibited or command gone
          if (!any_cmd || inh_sync_r) begin
            ack_state_r         <= ACK_IDLE;
            transfer_ack_oe_out <= 1'b0;
          end else if (ack_cnt_r >= ack_limit - CNT_W'(1)) begin
            ack_state_r        <= ACK_DONE;
            transfer_ack_n_out <= 1'b0;
          end else begin
            ack_cnt_r <= ack_cnt_r + CNT_W'(1);
          end
        end
        ACK_DONE: begin
          // Release on command removal; inhibit drops ack drive too
          if (!any_cmd || inh_sync_r) begin
            ack_state_r         <= ACK_IDLE;
            transfer_ack_n_out  <= 1'b1;
            transfer_ack_oe_out <= 1'b0;
          end
        end
        default: begin
          ack_state_r <= ACK_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Assertions
  a_ack_release_fast: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    ($fell(any_cmd) && ack_state_r == ACK_DONE) |=> transfer_ack_n_out)
    else $error("ack not released after command removal");
  a_ack_held_cmd: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ack_state_r == ACK_DONE && any_cmd && !inh_sync_r) |=> !transfer_ack_n_out)
    else $error("ack dropped while command present");
  a_inhibit_ack_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    inh_sync_r |=> !transfer_ack_oe_out)
    else $error("inhibited slave still drives ack");
  a_ack_oe_addressed: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !transfer_ack_n_out |-> transfer_ack_oe_out)
    else $error("ack low without drive");
  a_overlay_delay: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    ($rose(ack_state_r == ACK_WAIT) && overlay_hit) |-> transfer_ack_n_out [*8])
    else $error("overlay ack too early");
  a_delay_count: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $fell(transfer_ack_n_out) |-> (ack_cnt_r + CNT_W'(1) >= ack_limit))
    else $error("ack before delay count");
  a_inhibit_fast: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    overlay_hit |=> !overlay_inhibit_n_out)
    else $error("inhibit not asserted");
  a_inhibit_drops: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    inh_sync_r |=> (dev_sel_out == 8'h00 && !bus_data_oe_out))
    else $error("inhibited slave still selected");
  a_data_oe_read: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    bus_data_oe_out |-> $past(rd_cmd && base_match))
    else $error("data driven without read and match");
  a_sel_onehot: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    $onehot0(dev_sel_out))
    else $error("several device selects active");
  a_boot_only: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (boot_overlay_in && !boot_ok_r) |-> !overlay_hit)
    else $error("boot overlay outside boot");
  a_sync_path: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    cmd_sync_r == ~$past(bus_cmd_in, 2))
    else $error("command synchroniser depth wrong");
endmodule

// ### test/bus_master_model.sv
// Purpose: Bus master model issuing memory and I/O commands
// Assumes: Command and acknowledge lines idle high through pull-ups
// Notes:   Drives after rising edges; freed lines show inverted values
`timescale 1ns/1ps
module bus_master_model (
  // Clock and acknowledge
  input  wire logic               clk_in,
  input  wire logic               ack_n_in,
  input  wire logic               ack_oe_in,
  // Bus drive
  output logic [7:0]              addr_out,
  output slave_bus_pkg::bus_cmd_s cmd_out,
  output logic [7:0]              data_out
);
  import slave_bus_pkg::*;
  logic ack_wire; // Acknowledge line level with pull-up
  assign ack_wire = ack_oe_in ? ack_n_in : 1'b1;
  initial begin
    addr_out = 8'h00;
    cmd_out  = 4'hf;
    data_out = 8'h00;
  end
  // Address and write data ahead of command
  task automatic put_addr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
  endtask
  // Command after setup, bounded wait for acknowledge
  task automatic start(input int k, input int lim, output int lat);
    repeat (7) @(posedge clk_in);
    cmd_out <= ~(4'h8 >> k);
    lat = -1;
    for (int i = 0; i < lim && lat < 0; i++) begin
      @(posedge clk_in);
      #1;
      if (ack_wire === 1'b0) lat = i;
    end
  endtask
  // Remove command, time acknowledge release, then free lines
  task automatic stop(output int rel);
    @(posedge clk_in);
    cmd_out <= 4'hf;
    rel = -1;
    for (int i = 0; i < 20 && rel < 0; i++) begin
      @(posedge clk_in);
      #1;
      if (ack_oe_in === 1'b0 && ack_n_in === 1'b1) rel = i;
    end
    repeat (7) @(posedge clk_in);
    addr_out <= ~addr_out;
    data_out <= ~data_out;
  endtask
endmodule

// ### test/slave_bus_decode_inhibit_bench.sv
// Purpose: Self-checking bench for the slave decode and inhibit front end
// Assumes: Base top 2, base select 5 after reset
// Notes:   Overlay acknowledge delay shortened to 10 cycles
`timescale 1ns/1ps
module slave_bus_decode_inhibit_bench;
  import slave_bus_pkg::*;
  localparam int ACKD = 10; // Shortened overlay delay
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic inh_n = 1'b1;
  logic [2:0] bsel = 3'h5;
  logic [1:0] btop = 2'h2;
  logic ov_en = 1'b0;
  logic boot_ov = 1'b0;
  logic boot_dn = 1'b0;
  logic [7:0] udata = 8'h00;
  logic [7:0] addr, wdata, dsel, wr_data, bdata;
  bus_cmd_s cmd;
  local_strobe_s strb;
  logic oe, ack_n, ack_oe, inh_out;
  int mismatches = 0;
  int cmp_count = 0;
  int lat, rel;
  always #4 sys_clk_in = ~sys_clk_in;
  slave_bus_decode_inhibit #(.ACK_DELAY_CYC(ACKD)) dut_u (
    .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus_addr_in(addr),
    .bus_cmd_in(cmd), .bus_data_in(wdata), .overlay_inhibit_n_in(inh_n),
    .base_sel_in(bsel), .base_top_in(btop), .overlay_en_in(ov_en),
    .boot_overlay_in(boot_ov), .boot_done_in(boot_dn), .user_rd_data_in(udata),
    .dev_sel_out(dsel), .strobe_out(strb), .user_wr_data_out(wr_data),
    .bus_data_out(bdata), .bus_data_oe_out(oe), .transfer_ack_n_out(ack_n),
    .transfer_ack_oe_out(ack_oe), .overlay_inhibit_n_out(inh_out));
  bus_master_model mst_u (.clk_in(sys_clk_in), .ack_n_in(ack_n),
    .ack_oe_in(ack_oe), .addr_out(addr), .cmd_out(cmd), .data_out(wdata));
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Transfer helpers
  task automatic go(input logic [7:0] a, input int k, input int lim);
    mst_u.put_addr(a, 8'hc3 ^ a);
    mst_u.start(k, lim, lat);
  endtask
  task automatic finish_xfer;
    mst_u.stop(rel);
    chk(8'(rel inside {[0:12]}), 8'h01);
    if (rel < 0) give_verdict();
    chk({7'h00, oe}, 8'h00);
  endtask
  // No select, strobe, data or acknowledge drive
  task automatic chk_quiet;
    chk({4'h0, strb}, 8'h00);
    chk(dsel, 8'h00);
    chk({6'h00, oe, ack_oe}, 8'h00);
  endtask
  // ==========================================================
  // Scenarios
  task automatic sc_access;
    for (int k = 0; k < 4; k++) begin
      for (int d = 0; d < 8; d++) begin
        udata <= 8'h5a ^ (8'ha8 + 8'(d));
        go(8'ha8 + 8'(d), k, 20);
        chk(8'(lat >= 0), 8'h01);
        if (lat < 0) give_verdict();
        chk(dsel, 8'h01 << d);
        chk({4'h0, strb}, 8'(4'h8 >> k));
        chk({7'h00, oe}, 8'(k == 0 || k == 2));
        if (k == 0 || k == 2) chk(bdata, udata);
        else chk(wr_data, 8'hc3 ^ (8'ha8 + 8'(d)));
        finish_xfer();
      end
    end
  endtask
  task automatic sc_miss;
    @(posedge sys_clk_in);
    bsel <= 3'h2;
    go(8'ha8, 2, 20);
    chk(8'(lat), 8'hff);
    chk_quiet();
    finish_xfer();
    go(8'h13, 2, 20);
    chk(8'(lat), 8'hff);
    chk_quiet();
    finish_xfer();
    go(8'h93, 2, 20);
    chk(dsel, 8'h08);
    finish_xfer();
  endtask
  task automatic sc_overlay;
    int n;
    @(posedge sys_clk_in);
    ov_en <= 1'b1;
    mst_u.put_addr(8'h91, 8'h00);
    n = 0;
    #1;
    while (inh_out !== 1'b0 && n < 14) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    chk(8'(n <= 12), 8'h01);
    if (n > 12) give_verdict();
    mst_u.start(0, 40, lat);
    chk(8'(lat >= ACKD), 8'h01);
    finish_xfer();
    ov_en <= 1'b0;
  endtask
  task automatic sc_inhibited;
    go(8'h91, 0, 4);
    @(posedge sys_clk_in);
    inh_n <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    #1;
    chk_quiet();
    finish_xfer();
    inh_n <= 1'b1;
  endtask
  task automatic sc_boot;
    ov_en <= 1'b1;
    boot_ov <= 1'b1;
    go(8'h91, 2, 20);
    chk(8'(lat >= 0), 8'h01);
    chk({7'h00, inh_out}, 8'h00);
    finish_xfer();
    boot_dn <= 1'b1;
    @(posedge sys_clk_in);
    boot_dn <= 1'b0;
    go(8'h91, 2, 20);
    chk(8'(lat), 8'hff);
    chk({7'h00, inh_out}, 8'h01);
    finish_xfer();
  endtask
  initial begin
    repeat (20) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    sc_access();
    sc_miss();
    sc_overlay();
    sc_inhibited();
    sc_boot();
    give_verdict();
  end
endmodule
